/* File: tmz_timer.sv */
// 8-bit timer/counter with prescaler shared with the watchdog
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module tmz_timer
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Core and watchdog
    input  wire logic        i_sleep,
    input  wire logic        i_wdt_base_tick,
    output logic             o_wdt_tick,
    output logic             o_wdt_clear,
    output logic             o_timer_irq,
    // External count pin
    input  wire logic        i_ext_count_pin
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tmz_pkg::tmz_phase_t phase_ff;
    logic [7:0]  timer_count_reg_ff;
    logic [5:0]  option_ff;
    logic        timer_irq_enable_ff;
    logic        timer_overflow_flag_ff;
    logic [7:0]  psc_ff;
    logic [1:0]  inhib_ff;
    logic        pin_meta_ff;
    logic        pin_sync_ff;
    logic        lvl_prev_ff;
    logic        samp_ff;
    logic        wdt_prev_ff;
    logic        ack_ff;
    logic [31:0] rdat_ff;
    logic        wdt_tick_ff;
    logic        wdt_clear_ff;
    logic        irq_ff;

    logic        clock_source_select;
    logic        source_edge_select;
    logic        prescaler_assign;
    logic [2:0]  prescale_ratio;
    logic        bus_req;
    logic        bus_wr;
    logic        lane0;
    logic        count_wr;
    logic        option_wr;
    logic        intctl_wr;
    logic        clear_watchdog_cmd;
    logic        instr_tick;
    logic        sample_phase;
    logic        src_lvl;
    logic        ext_evt;
    logic        psc_evt;
    logic        psc_clr;
    logic        psc_out;
    logic        samp_in;
    logic        samp_rise;
    logic        timer_inc;
    logic        overflow;
    logic        flag_clr;
    logic [31:0] nxt_rdat;

    assign clock_source_select = option_ff[tmz_pkg::TMZ_OPT_CS_BIT];
    assign source_edge_select  = option_ff[tmz_pkg::TMZ_OPT_SE_BIT];
    assign prescaler_assign    = option_ff[tmz_pkg::TMZ_OPT_PSA_BIT];
    assign prescale_ratio      = option_ff[tmz_pkg::TMZ_OPT_PS_LSB +: 3];

    // ------------------------------------------------------------
    // Wishbone decode
    // ------------------------------------------------------------
    assign bus_req   = i_wb_cyc && i_wb_stb && !ack_ff;
    assign bus_wr    = bus_req && i_wb_we;
    assign lane0     = i_wb_sel[0];
    assign count_wr  = bus_wr && lane0 && (i_wb_adr == tmz_pkg::TMZ_OFS_COUNT);
    assign option_wr = bus_wr && lane0 && (i_wb_adr == tmz_pkg::TMZ_OFS_OPTION);
    assign intctl_wr = bus_wr && lane0 && (i_wb_adr == tmz_pkg::TMZ_OFS_INTCTL);
    assign clear_watchdog_cmd = bus_wr && lane0 && (i_wb_adr == tmz_pkg::TMZ_OFS_CMD)
                                && i_wb_dat[tmz_pkg::TMZ_CMD_CLRWD_BIT];

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            ack_ff <= 1'b0;
        else
            ack_ff <= bus_req;
    end

    // Prescaler count is deliberately absent from the read map
    always_comb
    begin
        nxt_rdat = 32'h0000_0000;
        case (i_wb_adr)
            tmz_pkg::TMZ_OFS_COUNT:  nxt_rdat[7:0] = timer_count_reg_ff;
            tmz_pkg::TMZ_OFS_OPTION: nxt_rdat[5:0] = option_ff;
            tmz_pkg::TMZ_OFS_INTCTL:
            begin
                nxt_rdat[tmz_pkg::TMZ_INT_IEN_BIT]  = timer_irq_enable_ff;
                nxt_rdat[tmz_pkg::TMZ_INT_FLAG_BIT] = timer_overflow_flag_ff;
            end
            default: nxt_rdat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            rdat_ff <= 32'h0000_0000;
        else if (bus_req && !i_wb_we)
            rdat_ff <= nxt_rdat;
    end

    // ------------------------------------------------------------
    // Option and interrupt control
    // ------------------------------------------------------------
    // Assignment and ratio may be rewritten at any time
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            option_ff <= tmz_pkg::TMZ_OPTION_RST[5:0];
        else if (option_wr)
            option_ff <= i_wb_dat[5:0];
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            timer_irq_enable_ff <= 1'b0;
        else if (intctl_wr)
            timer_irq_enable_ff <= i_wb_dat[tmz_pkg::TMZ_INT_IEN_BIT];
    end

    assign flag_clr = intctl_wr && !i_wb_dat[tmz_pkg::TMZ_INT_FLAG_BIT];
    assign overflow = timer_inc && (timer_count_reg_ff == 8'hff);

    // Overflow wins over a clear in the same cycle
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            timer_overflow_flag_ff <= 1'b0;
        else if (overflow)
            timer_overflow_flag_ff <= 1'b1;
        else if (flag_clr)
            timer_overflow_flag_ff <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            irq_ff <= 1'b0;
        else
            irq_ff <= timer_overflow_flag_ff && timer_irq_enable_ff;
    end

    // ------------------------------------------------------------
    // Phase generator, one instruction cycle is four core clocks
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            phase_ff <= tmz_pkg::TMZ_Q1;
        else
        begin
            case (phase_ff)
                tmz_pkg::TMZ_Q1: phase_ff <= tmz_pkg::TMZ_Q2;
                tmz_pkg::TMZ_Q2: phase_ff <= tmz_pkg::TMZ_Q3;
                tmz_pkg::TMZ_Q3: phase_ff <= tmz_pkg::TMZ_Q4;
                tmz_pkg::TMZ_Q4: phase_ff <= tmz_pkg::TMZ_Q1;
                default:         phase_ff <= tmz_pkg::TMZ_Q1;
            endcase
        end
    end

    assign instr_tick   = (phase_ff == tmz_pkg::TMZ_Q4);
    assign sample_phase = (phase_ff == tmz_pkg::TMZ_Q2) || (phase_ff == tmz_pkg::TMZ_Q4);

    // ------------------------------------------------------------
    // External pin synchroniser and edge select
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            // Matches falling-edge select after reset, so no false edge follows
            lvl_prev_ff <= 1'b1;
        end
        else
        begin
            pin_meta_ff <= i_ext_count_pin;
            pin_sync_ff <= pin_meta_ff;
            lvl_prev_ff <= src_lvl;
        end
    end

    // Inverting the pin turns a falling edge into a rising one
    assign src_lvl = pin_sync_ff ^ source_edge_select;
    assign ext_evt = src_lvl && !lvl_prev_ff;

    // ------------------------------------------------------------
    // Shared prescaler
    // ------------------------------------------------------------
    // One counter, fed by whichever side owns it
    always_comb
    begin
        if (prescaler_assign)
            psc_evt = i_wdt_base_tick;
        else if (clock_source_select)
            psc_evt = ext_evt && !i_sleep;
        else
            psc_evt = instr_tick && !i_sleep;
    end

    assign psc_clr = (count_wr && !prescaler_assign)
                     || (clear_watchdog_cmd && prescaler_assign);

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            psc_ff <= tmz_pkg::TMZ_PSC_RST;
        else if (psc_clr)
            psc_ff <= tmz_pkg::TMZ_PSC_RST;
        else if (psc_evt)
            psc_ff <= psc_ff + 8'h01;
    end

    // Bit n toggles every 2^n events, a period of 2^(n+1)
    assign psc_out = psc_ff[prescale_ratio];

    // ------------------------------------------------------------
    // Synchroniser at phases two and four
    // ------------------------------------------------------------
    assign samp_in = (clock_source_select && prescaler_assign) ? src_lvl : psc_out;

    always_ff @(posedge i_core_clk)
    begin
        // Reset high: the inverted idle pin reads high, which must not count
        if (!i_rst_n)
            samp_ff <= 1'b1;
        else if (sample_phase)
            samp_ff <= samp_in;
    end

    assign samp_rise = sample_phase && samp_in && !samp_ff;

    // ------------------------------------------------------------
    // Count register
    // ------------------------------------------------------------
    always_comb
    begin
        timer_inc = 1'b0;
        if (!i_sleep && (inhib_ff == 2'h0) && !count_wr)
        begin
            if (!clock_source_select && prescaler_assign)
                timer_inc = instr_tick;
            else
                timer_inc = samp_rise;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            inhib_ff <= 2'h0;
        else if (count_wr)
            inhib_ff <= tmz_pkg::TMZ_INHIBIT_INSTR;
        else if (instr_tick && (inhib_ff != 2'h0))
            inhib_ff <= inhib_ff - 2'h1;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            timer_count_reg_ff <= tmz_pkg::TMZ_COUNT_RST;
        else if (count_wr)
            timer_count_reg_ff <= i_wb_dat[7:0];
        else if (timer_inc)
            timer_count_reg_ff <= timer_count_reg_ff + 8'h01;
    end

    // ------------------------------------------------------------
    // Watchdog side
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            wdt_prev_ff  <= 1'b0;
            wdt_tick_ff  <= 1'b0;
            wdt_clear_ff <= 1'b0;
        end
        else
        begin
            wdt_prev_ff  <= psc_out;
            wdt_tick_ff  <= prescaler_assign && psc_out && !wdt_prev_ff;
            wdt_clear_ff <= clear_watchdog_cmd;
        end
    end

    assign o_wb_ack    = ack_ff;
    assign o_wb_dat    = rdat_ff;
    assign o_wdt_tick  = wdt_tick_ff;
    assign o_wdt_clear = wdt_clear_ff;
    assign o_timer_irq = irq_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    ovf_flag_set_a: assert property (overflow |=> timer_overflow_flag_ff)
        else $error("overflow did not set flag");
    flag_sticky_a: assert property (timer_overflow_flag_ff && !flag_clr |=> timer_overflow_flag_ff)
        else $error("overflow flag dropped on its own");
    irq_mask_a: assert property (!timer_irq_enable_ff |=> !o_timer_irq)
        else $error("interrupt raised while masked");
    write_inhibit_a: assert property (count_wr |=> (!timer_inc)[*5])
        else $error("count advanced right after write");
    sleep_stop_a: assert property (i_sleep |-> !timer_inc)
        else $error("count advanced in sleep");
    instr_inc_a: assert property (instr_tick && !clock_source_select && prescaler_assign
        && inhib_ff == 2'h0 && !i_sleep && !count_wr
        |=> timer_count_reg_ff == 8'($past(timer_count_reg_ff) + 8'h01))
        else $error("timer mode missed an instruction cycle");
    psc_clr_tmr_a: assert property (count_wr && !prescaler_assign |=> psc_ff == 8'h00)
        else $error("count write kept prescaler");
    psc_clr_wdt_a: assert property (clear_watchdog_cmd && prescaler_assign
        |=> psc_ff == 8'h00 && o_wdt_clear)
        else $error("watchdog clear kept prescaler");
    wdt_only_a: assert property (!prescaler_assign |=> !o_wdt_tick)
        else $error("watchdog tick while prescaler on timer");
    samp_phase_a: assert property (!sample_phase |=> samp_ff == $past(samp_ff))
        else $error("sampling outside phases two and four");
    bus_ack_a: assert property (bus_req |=> o_wb_ack ##1 !o_wb_ack)
        else $error("bus ack not a single cycle");

    wrap_c:    cover property (overflow && timer_irq_enable_ff);
    ext_cnt_c: cover property (clock_source_select && timer_inc);
    psc_256_c: cover property (!prescaler_assign && prescale_ratio == 3'h7 && timer_inc);
    wdt_c:     cover property (o_wdt_tick);

endmodule

/* File: tmz_pkg.sv */
// Shared constants and types for the timer with shared prescaler
package tmz_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0] TMZ_OFS_COUNT  = 4'h0;
    localparam logic [3:0] TMZ_OFS_OPTION = 4'h4;
    localparam logic [3:0] TMZ_OFS_INTCTL = 4'h8;
    localparam logic [3:0] TMZ_OFS_CMD    = 4'hc;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TMZ_OPT_CS_BIT     = 5;
    localparam int TMZ_OPT_SE_BIT     = 4;
    localparam int TMZ_OPT_PSA_BIT    = 3;
    localparam int TMZ_OPT_PS_LSB     = 0;
    localparam int TMZ_INT_IEN_BIT    = 5;
    localparam int TMZ_INT_FLAG_BIT   = 2;
    localparam int TMZ_CMD_CLRWD_BIT  = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TMZ_OPTION_RST = 8'hff;
    localparam logic [7:0] TMZ_COUNT_RST  = 8'h00;
    localparam logic [7:0] TMZ_PSC_RST    = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         TMZ_CLK_PERIOD_PS = 5000;
    localparam int         TMZ_TOSC_PS       = 5000;
    localparam int         TMZ_TOSC_CYC      = TMZ_TOSC_PS / TMZ_CLK_PERIOD_PS;
    localparam logic [1:0] TMZ_INHIBIT_INSTR = 2'h2;

    // Internal phases of one instruction cycle
    typedef enum logic [3:0] {
        TMZ_Q1 = 4'b0001,
        TMZ_Q2 = 4'b0010,
        TMZ_Q3 = 4'b0100,
        TMZ_Q4 = 4'b1000
    } tmz_phase_t;

endpackage

/* File: tmz_ext_src.sv */
// Model of the external clock source on the counter input pin
`timescale 1ns/1ps
module tmz_ext_src
(
    // Clock
    input  wire logic i_core_clk,
    // Count pin
    output logic      o_pin
);
    // Each level is held past two core clocks plus the three-clock sync window
    localparam int HALF = 6;

    initial o_pin = 1'b0;

    task automatic level(input logic v);
        @(posedge i_core_clk);
        o_pin <= v;
        repeat (HALF - 1) @(posedge i_core_clk);
    endtask

    // Full pulses; the pin rests low between bursts
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++)
        begin
            level(1'b1);
            level(1'b0);
        end
    endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the timer with shared prescaler
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CNT = tmz_pkg::TMZ_OFS_COUNT;
    localparam logic [3:0] OFS_OPT = tmz_pkg::TMZ_OFS_OPTION;
    localparam logic [3:0] OFS_INT = tmz_pkg::TMZ_OFS_INTCTL;
    localparam logic [3:0] OFS_CMD = tmz_pkg::TMZ_OFS_CMD;
    typedef struct packed
    {
        logic [7:0] opt;
        int         gap;
        int         pulses;
        logic [7:0] delta;
    } tmz_row_t;
    logic        i_core_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_sleep;
    logic [3:0]  i_wb_adr, i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, rd, a;
    logic        o_wb_ack, i_wdt_base_tick, o_wdt_tick, o_wdt_clear, o_timer_irq;
    logic        i_ext_count_pin;
    int          error_cnt, num_checks, cyc_cnt, tick_cnt, clr_cnt, b;
    // Option, spacing of the two reads, pin pulses, expected count advance
    tmz_row_t    rows [14] = '{
        '{8'h08, 40, 0, 8'h0a}, '{8'h00, 24, 0, 8'h03}, '{8'h01, 48, 0, 8'h03},
        '{8'h02, 96, 0, 8'h03}, '{8'h03, 192, 0, 8'h03}, '{8'h04, 384, 0, 8'h03},
        '{8'h05, 768, 0, 8'h03}, '{8'h06, 1536, 0, 8'h03}, '{8'h07, 3072, 0, 8'h03},
        '{8'h28, 0, 5, 8'h05}, '{8'h38, 0, 5, 8'h05}, '{8'h20, 0, 4, 8'h02},
        '{8'h21, 0, 8, 8'h02}, '{8'h27, 0, 256, 8'h01}
    };

    tmz_timer u_dut
    (
        .i_core_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
        .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_sleep, .i_wdt_base_tick, .o_wdt_tick,
        .o_wdt_clear, .o_timer_irq, .i_ext_count_pin
    );
    tmz_ext_src u_src
    (
        .i_core_clk (i_core_clk),
        .o_pin      (i_ext_count_pin)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic cycle: request taken one edge before ack, released at the ack edge
    task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= adr;
        i_wb_dat <= {24'h000000, d};
        do
            @(posedge i_core_clk);
        while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_core_clk);
    endtask

    // Count advance between two reads taken gap edges apart, or around pin pulses
    task automatic span(input int gap, input int pulses);
        wb(1'b0, OFS_CNT, 8'h00);
        a = rd;
        if (pulses > 0)
        begin
            u_src.pulse(pulses);
            repeat (8) @(posedge i_core_clk);
        end
        else
            repeat (gap - 3) @(posedge i_core_clk);
        wb(1'b0, OFS_CNT, 8'h00);
        rd = {24'h000000, rd[7:0] - a[7:0]};
    endtask

    task automatic base(input int n);
        repeat (n)
        begin
            i_wdt_base_tick <= 1'b1;
            @(posedge i_core_clk);
            i_wdt_base_tick <= 1'b0;
            repeat (3) @(posedge i_core_clk);
        end
    endtask

    // ----------------------------------------------------------------
    // Clock, monitors and timeout
    // ----------------------------------------------------------------
    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (o_wdt_tick === 1'b1)
            tick_cnt <= tick_cnt + 1;
        if (o_wdt_clear === 1'b1)
            clr_cnt <= clr_cnt + 1;
        if (cyc_cnt == 30000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        {i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_sleep, i_wdt_base_tick} = '0;
        {i_wb_adr, i_wb_dat, cyc_cnt, tick_cnt, clr_cnt} = '0;
        i_wb_sel = 4'hf;
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        wb(1'b0, OFS_OPT, 8'h00);
        check("option reset", rd, {24'h0, tmz_pkg::TMZ_OPTION_RST & 8'h3f});
        wb(1'b0, OFS_CNT, 8'h00);
        check("count reset", rd, {24'h0, tmz_pkg::TMZ_COUNT_RST});
        wb(1'b0, OFS_INT, 8'h00);
        check("intctl reset", rd, 32'h00000000);
        wb(1'b1, 4'h2, 8'haa);
        wb(1'b0, 4'h2, 8'h00);
        check("unmapped read", rd, 32'h00000000);
        foreach (rows[i])
        begin
            wb(1'b1, OFS_OPT, rows[i].opt);
            repeat (8) @(posedge i_core_clk);
            span(rows[i].gap, rows[i].pulses);
            check("count advance", rd, {24'h0, rows[i].delta});
        end
        // Single edges tell the selected polarity apart
        for (int s = 0; s < 2; s++)
        begin
            wb(1'b1, OFS_OPT, (s == 0) ? 8'h28 : 8'h38);
            repeat (8) @(posedge i_core_clk);
            wb(1'b0, OFS_CNT, 8'h00);
            a = rd;
            u_src.level(1'b1);
            repeat (8) @(posedge i_core_clk);
            wb(1'b0, OFS_CNT, 8'h00);
            check("rise counted", rd - a, (s == 0) ? 32'h1 : 32'h0);
            u_src.level(1'b0);
            repeat (8) @(posedge i_core_clk);
            wb(1'b0, OFS_CNT, 8'h00);
            check("one edge counted", rd - a, 32'h1);
        end
        // Write inhibit: of nine or ten ticks two are skipped
        wb(1'b1, OFS_OPT, 8'h08);
        wb(1'b1, OFS_CNT, 8'h10);
        repeat (37) @(posedge i_core_clk);
        wb(1'b0, OFS_CNT, 8'h00);
        check("inhibit", 32'(rd[7:0] - 8'h10 inside {8'h07, 8'h08}), 32'h1);
        // A count write restarts the prescaler, so the first rise is half a period away
        wb(1'b1, OFS_OPT, 8'h07);
        repeat (600) @(posedge i_core_clk);
        wb(1'b1, OFS_CNT, 8'h20);
        repeat (477) @(posedge i_core_clk);
        wb(1'b0, OFS_CNT, 8'h00);
        check("no early rise", rd, 32'h20);
        repeat (117) @(posedge i_core_clk);
        wb(1'b0, OFS_CNT, 8'h00);
        check("first rise", rd, 32'h21);
        // Overflow, masking and sticky flag
        wb(1'b1, OFS_OPT, 8'h08);
        wb(1'b1, OFS_INT, 8'h20);
        wb(1'b1, OFS_CNT, 8'hfe);
        repeat (24) @(posedge i_core_clk);
        wb(1'b0, OFS_INT, 8'h00);
        check("flag on wrap", rd, 32'h24);
        check("irq enabled", o_timer_irq, 1'b1);
        wb(1'b1, OFS_INT, 8'h04);
        repeat (2) @(posedge i_core_clk);
        check("irq masked", o_timer_irq, 1'b0);
        wb(1'b1, OFS_INT, 8'h24);
        repeat (2) @(posedge i_core_clk);
        check("irq flag kept", o_timer_irq, 1'b1);
        wb(1'b1, OFS_INT, 8'h20);
        wb(1'b0, OFS_INT, 8'h00);
        check("flag cleared", rd, 32'h20);
        check("irq cleared", o_timer_irq, 1'b0);
        // Sleep freezes the count at ff, so no wrap follows
        wb(1'b1, OFS_CNT, 8'hff);
        i_sleep <= 1'b1;
        repeat (40) @(posedge i_core_clk);
        wb(1'b0, OFS_CNT, 8'h00);
        check("sleep count", rd, 32'hff);
        wb(1'b0, OFS_INT, 8'h00);
        check("sleep flag", rd, 32'h20);
        i_sleep <= 1'b0;
        // Prescaler, already on the watchdog, given ratio 1 after a clear, then cleared again
        b = clr_cnt;
        wb(1'b1, OFS_CMD, 8'h01);
        wb(1'b1, OFS_OPT, 8'h09);
        base(1);
        wb(1'b1, OFS_CMD, 8'h01);
        check("clear pulses", clr_cnt - b, 32'h2);
        b = tick_cnt;
        base(1);
        check("cleared postscaler", tick_cnt - b, 32'h0);
        base(1);
        check("postscaler tick", tick_cnt - b, 32'h1);
        wb(1'b1, OFS_OPT, 8'h01);
        b = tick_cnt;
        base(8);
        check("no watchdog tick", tick_cnt - b, 32'h0);
        end_of_test();
    end
endmodule
